// File: rtl/dcl_pkg.sv
package dcl_pkg;

	localparam int         CLK_PERIOD_NS  = 10;
	localparam int         STARTUP_NS     = 1000;
	localparam int         STARTUP_CYC    = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int         CNT_W          = 16;

	localparam logic [7:0] OFS_CONTROL    = 8'h00;
	localparam logic [7:0] OFS_CODE       = 8'h01;
	localparam logic [7:0] OFS_STATUS     = 8'h02;

	localparam int         BIT_STANDBY_RUN = 7;
	localparam int         BIT_PIN_OE      = 6;
	localparam int         BIT_ENABLE      = 0;

	localparam logic [7:0] CONTROL_RESET  = 8'h00;
	localparam logic [7:0] CODE_RESET     = 8'h00;
	localparam logic [7:0] CONTROL_MASK   = 8'hc1;
	localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

	typedef struct packed {
		logic       standby_run;
		logic       pin_output_enable;
		logic [4:0] rsvd;
		logic       enable;
	} dcl_ctrl_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} dcl_bus_t;

	typedef struct packed {
		logic halted;
		logic ready;
		logic buf_on;
		logic active;
	} dcl_stat_t;

	typedef enum logic [1:0] {
		PWR_OFF     = 2'b00,
		PWR_STARTUP = 2'b01,
		PWR_ACTIVE  = 2'b10,
		PWR_HALTED  = 2'b11
	} dcl_pwr_t;

	// Sleep condition under which the converter must be powered down.
	function automatic logic dcl_halt_req(input logic standby, input logic powerdown,
		input logic standby_run, input logic clk_avail);
		dcl_halt_req = powerdown | (standby & ~(standby_run & clk_avail));
	endfunction

endpackage

// File: rtl/dcl_regs.sv
`timescale 1ns/1ps
`default_nettype none
module dcl_regs (
	input  wire logic              clk,         // Peripheral clock.
	input  wire logic              rst_n,       // Asynchronous reset, active low.
	input  wire dcl_pkg::dcl_bus_t bus,         // Register port request.
	input  wire dcl_pkg::dcl_stat_t status,     // Power sequencing state.
	output dcl_pkg::dcl_ctrl_t     ctrl,        // Control register.
	output logic [7:0]             code,        // Code register.
	output logic [7:0]             rdata,       // Read data, cycle after strobe.
	output logic                   code_wr,     // Code register written.
	output logic                   enable_rise  // Enable written from zero to one.
);
	logic sel_control;
	logic sel_code;

	assign sel_control = bus.addr == dcl_pkg::OFS_CONTROL;
	assign sel_code    = bus.addr == dcl_pkg::OFS_CODE;
	assign code_wr     = bus.wr & sel_code;
	assign enable_rise = bus.wr & sel_control & bus.wdata[dcl_pkg::BIT_ENABLE] & ~ctrl.enable;

	// Reserved bits are masked on the way in so they can never read back set.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= dcl_pkg::CONTROL_RESET;
		end else if (bus.wr && sel_control) begin
			ctrl <= bus.wdata & dcl_pkg::CONTROL_MASK;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			code <= dcl_pkg::CODE_RESET;
		end else if (code_wr) begin
			code <= bus.wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= dcl_pkg::UNMAPPED_RDATA;
		end else if (bus.rd) begin
			case (bus.addr)
				dcl_pkg::OFS_CONTROL: rdata <= ctrl;
				dcl_pkg::OFS_CODE:    rdata <= code;
				dcl_pkg::OFS_STATUS:  rdata <= {4'h0, status};
				default:              rdata <= dcl_pkg::UNMAPPED_RDATA;
			endcase
		end else begin
			rdata <= dcl_pkg::UNMAPPED_RDATA;
		end
	end
endmodule
`default_nettype wire

// File: rtl/dcl_power.sv
`timescale 1ns/1ps
`default_nettype none
module dcl_power #(
	parameter int STARTUP_CYC = dcl_pkg::STARTUP_CYC // Settling cycles after power-up.
) (
	input  wire logic         clk,         // Peripheral clock.
	input  wire logic         rst_n,       // Asynchronous reset, active low.
	input  wire logic         enable,      // Converter enable bit.
	input  wire logic         pin_oe,      // Pin output enable bit.
	input  wire logic         halt_req,    // Sleep requires power-down.
	output dcl_pkg::dcl_pwr_t state,       // Power state.
	output dcl_pkg::dcl_stat_t status      // Decoded power status.
);
	localparam logic [dcl_pkg::CNT_W-1:0] LAST = dcl_pkg::CNT_W'(STARTUP_CYC - 1);

	dcl_pkg::dcl_pwr_t          next_state;
	logic [dcl_pkg::CNT_W-1:0] cnt;

	always_comb begin
		next_state = state;
		case (state)
			dcl_pkg::PWR_OFF: begin
				if (enable && !halt_req) next_state = dcl_pkg::PWR_STARTUP;
			end
			dcl_pkg::PWR_STARTUP: begin
				if (!enable) next_state = dcl_pkg::PWR_OFF;
				else if (halt_req) next_state = dcl_pkg::PWR_HALTED;
				else if (cnt == LAST) next_state = dcl_pkg::PWR_ACTIVE;
			end
			dcl_pkg::PWR_ACTIVE: begin
				if (!enable) next_state = dcl_pkg::PWR_OFF;
				else if (halt_req) next_state = dcl_pkg::PWR_HALTED;
			end
			dcl_pkg::PWR_HALTED: begin
				if (!enable) next_state = dcl_pkg::PWR_OFF;
				else if (!halt_req) next_state = dcl_pkg::PWR_STARTUP;
			end
			default: next_state = dcl_pkg::PWR_OFF;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= dcl_pkg::PWR_OFF;
		end else begin
			state <= next_state;
		end
	end

	// The start-up count restarts on every entry, so a wake always waits out the full settling time.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= '0;
		end else if (state != dcl_pkg::PWR_STARTUP || next_state != dcl_pkg::PWR_STARTUP) begin
			cnt <= '0;
		end else begin
			cnt <= cnt + 1'b1;
		end
	end

	assign status.active = state == dcl_pkg::PWR_STARTUP || state == dcl_pkg::PWR_ACTIVE;
	assign status.buf_on = status.active & pin_oe;
	assign status.ready  = state == dcl_pkg::PWR_ACTIVE;
	assign status.halted = state == dcl_pkg::PWR_HALTED;
endmodule
`default_nettype wire

// File: rtl/dcl_top.sv
`timescale 1ns/1ps
`default_nettype none
module dcl_top #(
	parameter int STARTUP_CYC = dcl_pkg::STARTUP_CYC // Settling cycles after power-up.
) (
	input  wire logic       CORE_CLK,        // Peripheral clock, 100 MHz.
	input  wire logic       RSTN,            // Asynchronous reset, active low.
	input  wire logic [7:0] REG_ADDR,        // Register address.
	input  wire logic [7:0] REG_WDATA,       // Register write data.
	input  wire logic       REG_WR,          // Write strobe.
	input  wire logic       REG_RD,          // Read strobe.
	output logic      [7:0] REG_RDATA,       // Read data, cycle after read strobe.
	input  wire logic       SLEEP_STANDBY,   // Device is in standby sleep.
	input  wire logic       SLEEP_POWERDOWN, // Device is in power-down sleep.
	input  wire logic       CLK_PER_AVAIL,   // Peripheral clock kept in standby.
	output logic      [7:0] DAC_CODE,        // Code presented to the string.
	output logic            CONV_START,      // One-cycle conversion start.
	output logic            DAC_POWER,       // Converter string powered.
	output logic            BUF_ENABLE,      // Output buffer on, routed to pin.
	output logic            INT_OFFER,       // Output offered to comparator and ADC.
	output logic            DAC_READY        // Start-up settling complete.
);
	dcl_pkg::dcl_bus_t  bus;
	dcl_pkg::dcl_ctrl_t ctrl;
	dcl_pkg::dcl_stat_t status;
	dcl_pkg::dcl_pwr_t  pwr_state;
	logic [7:0]         code;
	logic               code_wr;
	logic               enable_rise;
	logic               halt_req;
	logic               halted_now;
	logic               start_req;
	logic               conv_pending;
	logic               fire;

	assign bus.addr  = REG_ADDR;
	assign bus.wdata = REG_WDATA;
	assign bus.wr    = REG_WR;
	assign bus.rd    = REG_RD;

	// Debug halt has no input here at all, so registers and sequencing keep running through it.
	dcl_regs u_regs (
		.clk         (CORE_CLK),
		.rst_n       (RSTN),
		.bus         (bus),
		.status      (status),
		.ctrl        (ctrl),
		.code        (code),
		.rdata       (REG_RDATA),
		.code_wr     (code_wr),
		.enable_rise (enable_rise)
	);

	assign halt_req = dcl_pkg::dcl_halt_req(SLEEP_STANDBY, SLEEP_POWERDOWN,
		ctrl.standby_run, CLK_PER_AVAIL);

	dcl_power #(
		.STARTUP_CYC (STARTUP_CYC)
	) u_power (
		.clk      (CORE_CLK),
		.rst_n    (RSTN),
		.enable   (ctrl.enable),
		.pin_oe   (ctrl.pin_output_enable),
		.halt_req (halt_req),
		.state    (pwr_state),
		.status   (status)
	);

	// A write to the code register only triggers while enabled; enabling triggers on the held code.
	assign start_req  = (code_wr & ctrl.enable) | enable_rise;
	assign halted_now = halt_req | status.halted;

	// A start that arrives while the string is powered down is held and replayed on wake.
	assign fire = (start_req & ~halted_now) | (conv_pending & ~halted_now & ctrl.enable);

	// Pending request: a new request wins over the clear in the same cycle.
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			conv_pending <= 1'b0;
		end else if (start_req && halted_now) begin
			conv_pending <= 1'b1;
		end else if (fire || !ctrl.enable) begin
			conv_pending <= 1'b0;
		end
	end

	// The converted code is taken from the write data directly so a start costs no extra cycle.
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			DAC_CODE <= dcl_pkg::CODE_RESET;
		end else if (fire) begin
			DAC_CODE <= code_wr ? REG_WDATA : code;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			CONV_START <= 1'b0;
		end else begin
			CONV_START <= fire;
		end
	end

	assign DAC_POWER  = status.active;
	assign BUF_ENABLE = status.buf_on;
	assign INT_OFFER  = status.active & ctrl.enable;
	assign DAC_READY  = status.ready;

	default clocking cb @(posedge CORE_CLK);
	endclocking

	default disable iff (!RSTN);

	sequence s_code_write_enabled;
		REG_WR && REG_ADDR == dcl_pkg::OFS_CODE && ctrl.enable && !halted_now;
	endsequence

	// A string still parked in the halted state blocks the start even after the sleep input drops.
	sequence s_enable_from_off;
		REG_WR && REG_ADDR == dcl_pkg::OFS_CONTROL && REG_WDATA[dcl_pkg::BIT_ENABLE]
			&& !ctrl.enable && !halted_now;
	endsequence

	sequence s_wake;
		pwr_state == dcl_pkg::PWR_HALTED && !halt_req && ctrl.enable;
	endsequence

	a_enable_bit_on: assert property (
		REG_WR && REG_ADDR == dcl_pkg::OFS_CONTROL && REG_WDATA[dcl_pkg::BIT_ENABLE] && !halt_req
		|=> ctrl.enable ##1 (DAC_POWER || $past(halt_req)))
		else $error("enable write did not power the converter");

	a_enable_bit_off: assert property (
		REG_WR && REG_ADDR == dcl_pkg::OFS_CONTROL && !REG_WDATA[dcl_pkg::BIT_ENABLE]
		|=> !ctrl.enable ##1 !DAC_POWER && !INT_OFFER)
		else $error("disable write left the converter active");

	a_code_write_start: assert property (
		s_code_write_enabled |=> CONV_START && DAC_CODE == $past(REG_WDATA))
		else $error("enabled code write did not start a conversion");

	a_disabled_store: assert property (
		REG_WR && REG_ADDR == dcl_pkg::OFS_CODE && !ctrl.enable && !conv_pending
		|=> !CONV_START && $stable(DAC_CODE) && code == $past(REG_WDATA))
		else $error("disabled code write started a conversion");

	a_enable_start: assert property (
		s_enable_from_off |=> CONV_START && DAC_CODE == code)
		else $error("enable did not convert the held code");

	a_buf_follows_pin: assert property (
		BUF_ENABLE == (DAC_POWER && ctrl.pin_output_enable))
		else $error("output buffer disagrees with pin output enable");

	a_int_offer_enable: assert property (
		INT_OFFER |-> ctrl.enable && DAC_POWER)
		else $error("internal offer without enable");

	a_int_no_pin: assert property (
		pwr_state == dcl_pkg::PWR_ACTIVE && ctrl.enable && !ctrl.pin_output_enable
		|-> INT_OFFER && !BUF_ENABLE)
		else $error("internal offer lost with pin output disabled");

	a_standby_runs: assert property (
		pwr_state == dcl_pkg::PWR_ACTIVE && SLEEP_STANDBY && !SLEEP_POWERDOWN
			&& ctrl.standby_run && CLK_PER_AVAIL && ctrl.enable
		|=> DAC_POWER)
		else $error("converter stopped in standby with standby run set");

	a_standby_halts: assert property (
		SLEEP_STANDBY && !ctrl.standby_run && DAC_POWER
		|=> pwr_state == dcl_pkg::PWR_HALTED || pwr_state == dcl_pkg::PWR_OFF)
		else $error("converter kept running in standby without standby run");

	a_halt_powers_down: assert property (
		pwr_state == dcl_pkg::PWR_HALTED |-> !DAC_POWER && !BUF_ENABLE && !INT_OFFER)
		else $error("halted converter still powered");

	a_no_start_halted: assert property (
		halted_now |=> !CONV_START)
		else $error("conversion started while halted");

	a_wake_restart: assert property (
		s_wake |=> DAC_POWER && BUF_ENABLE == ctrl.pin_output_enable
			&& pwr_state == dcl_pkg::PWR_STARTUP)
		else $error("wake did not restart converter and buffer");

	a_wake_replay: assert property (
		(s_wake and conv_pending) ##1 (!halt_req && ctrl.enable) |=> CONV_START && !conv_pending)
		else $error("held start not replayed on wake");

	a_powerdown_off: assert property (
		SLEEP_POWERDOWN |=> !DAC_POWER && !BUF_ENABLE)
		else $error("converter powered in power-down sleep");

	a_code_hold: assert property (
		!fire |=> $stable(DAC_CODE))
		else $error("presented code changed without a conversion");

	a_code_readback: assert property (
		REG_RD && REG_ADDR == dcl_pkg::OFS_CODE |=> REG_RDATA == $past(code))
		else $error("code register read back wrong");

	a_reserved_zero: assert property (
		REG_RD && REG_ADDR == dcl_pkg::OFS_CONTROL
		|=> REG_RDATA[5:1] == 5'h00 && REG_RDATA[7] == $past(ctrl.standby_run)
			&& REG_RDATA[6] == $past(ctrl.pin_output_enable)
			&& REG_RDATA[0] == $past(ctrl.enable))
		else $error("control read back wrong");

	a_ready_after_startup: assert property (
		$rose(DAC_READY) |-> $past(pwr_state) == dcl_pkg::PWR_STARTUP)
		else $error("ready raised without settling");

	a_read_one_cycle: assert property (
		!REG_RD |=> REG_RDATA == dcl_pkg::UNMAPPED_RDATA)
		else $error("read data outside its cycle");

endmodule
`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int SC = 4;

	logic       CORE_CLK;
	logic       RSTN;
	logic [7:0] REG_ADDR;
	logic [7:0] REG_WDATA;
	logic       REG_WR;
	logic       REG_RD;
	logic [7:0] REG_RDATA;
	logic       SLEEP_STANDBY;
	logic       SLEEP_POWERDOWN;
	logic       CLK_PER_AVAIL;
	logic [7:0] DAC_CODE;
	logic       CONV_START;
	logic       DAC_POWER;
	logic       BUF_ENABLE;
	logic       INT_OFFER;
	logic       DAC_READY;

	int         fails;
	int         compares;
	int         st;
	int         st_n;
	int         cnt;
	int         cnt_n;
	int         pend;
	logic       h;
	logic       hn;
	logic       go;
	logic [7:0] m_ctl;
	logic [7:0] m_code;
	logic [7:0] e_rd;
	logic [7:0] e_code;
	logic       e_start;
	logic       pow;
	logic [31:0] rnd;
	logic [7:0] a;

	dcl_top #(.STARTUP_CYC(SC)) u_dut (
		.CORE_CLK        (CORE_CLK),
		.RSTN            (RSTN),
		.REG_ADDR        (REG_ADDR),
		.REG_WDATA       (REG_WDATA),
		.REG_WR          (REG_WR),
		.REG_RD          (REG_RD),
		.REG_RDATA       (REG_RDATA),
		.SLEEP_STANDBY   (SLEEP_STANDBY),
		.SLEEP_POWERDOWN (SLEEP_POWERDOWN),
		.CLK_PER_AVAIL   (CLK_PER_AVAIL),
		.DAC_CODE        (DAC_CODE),
		.CONV_START      (CONV_START),
		.DAC_POWER       (DAC_POWER),
		.BUF_ENABLE      (BUF_ENABLE),
		.INT_OFFER       (INT_OFFER),
		.DAC_READY       (DAC_READY)
	);

	initial begin
		CORE_CLK = 1'b0;
		forever #5 CORE_CLK = ~CORE_CLK;
	end

	// Reference model: sees the same pre-edge inputs as the design at each rising edge.
	always @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			st = 0; cnt = 0; pend = 0; m_ctl = 8'h00; m_code = 8'h00;
			e_rd = 8'h00; e_code = 8'h00; e_start = 1'b0;
		end else begin
			h = SLEEP_POWERDOWN | (SLEEP_STANDBY & ~(m_ctl[7] & CLK_PER_AVAIL));
			st_n = st;
			cnt_n = cnt;
			if (!m_ctl[0]) st_n = 0;
			else if (h) st_n = (st == 0) ? 0 : 3;
			else if (st == 1) begin
				if (cnt == SC - 1) st_n = 2;
				else cnt_n = cnt + 1;
			end else if (st != 2) begin
				st_n = 1;
				cnt_n = 0;
			end
			go = (REG_WR && REG_ADDR == 8'h01 && m_ctl[0]) ||
				(REG_WR && REG_ADDR == 8'h00 && REG_WDATA[0] && !m_ctl[0]);
			// The halted state still blocks starts on the wake edge; held starts replay only while enabled.
			hn = h || st == 3;
			e_start = (go || (pend != 0 && m_ctl[0])) && !hn;
			if (e_start) e_code = (REG_WR && REG_ADDR == 8'h01) ? REG_WDATA : m_code;
			if (go && hn) pend = 1;
			else if (e_start || !m_ctl[0]) pend = 0;
			e_rd = 8'h00;
			if (REG_RD) begin
				case (REG_ADDR)
					8'h00: e_rd = m_ctl;
					8'h01: e_rd = m_code;
					8'h02: e_rd = {4'h0, st == 3, st == 2, (st == 1 || st == 2) && m_ctl[6], st == 1 || st == 2};
					default: e_rd = 8'h00;
				endcase
			end
			if (REG_WR && REG_ADDR == 8'h00) m_ctl = REG_WDATA & 8'hc1;
			if (REG_WR && REG_ADDR == 8'h01) m_code = REG_WDATA;
			st = st_n;
			cnt = cnt_n;
		end
	end

	task automatic chk(input logic [7:0] g, input logic [7:0] e, input string s);
		compares++;
		if (g !== e) begin
			fails++;
			$display("ERROR %0t %s got %h exp %h", $time, s, g, e);
		end
	endtask

	always @(negedge CORE_CLK) begin
		if (RSTN) begin
			pow = (st == 1 || st == 2);
			chk(REG_RDATA, e_rd, "read data");
			chk(DAC_CODE, e_code, "code");
			chk({7'h00, CONV_START}, {7'h00, e_start}, "start");
			chk({7'h00, DAC_POWER}, {7'h00, pow}, "power");
			chk({7'h00, BUF_ENABLE}, {7'h00, pow & m_ctl[6]}, "buffer");
			chk({7'h00, INT_OFFER}, {7'h00, pow & m_ctl[0]}, "offer");
			chk({7'h00, DAC_READY}, {7'h00, st == 2}, "ready");
		end
	end

	task automatic test_done();
		if (fails == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Each signal is assigned once per call, so back-to-back calls never double-drive a strobe.
	task automatic bus(input logic w, input logic r, input logic [7:0] ad, input logic [7:0] d);
		REG_WR <= w;
		REG_RD <= r;
		REG_ADDR <= ad;
		REG_WDATA <= d;
		@(posedge CORE_CLK);
	endtask

	task automatic cyc(input int n);
		repeat (n) bus(1'b0, 1'b0, 8'h00, 8'h00);
	endtask

	// Ready is looked at on the falling edge, where it has settled; the inputs stay idle meanwhile.
	task automatic wait_ready();
		for (int i = 0; i < 40; i++) begin
			@(negedge CORE_CLK);
			if (DAC_READY === 1'b1) begin
				@(posedge CORE_CLK);
				return;
			end
		end
		fails++;
		$display("ERROR %0t ready wait ran out", $time);
		test_done();
	endtask

	initial begin
		RSTN = 1'b0; REG_ADDR = 8'h00; REG_WDATA = 8'h00; REG_WR = 1'b0; REG_RD = 1'b0;
		SLEEP_STANDBY = 1'b0; SLEEP_POWERDOWN = 1'b0; CLK_PER_AVAIL = 1'b1;
		fails = 0;
		compares = 0;
		void'($urandom(32'h93c1fd38));
		repeat (3) @(posedge CORE_CLK);
		RSTN <= 1'b1;
		bus(1'b0, 1'b1, 8'h00, 8'h00);
		bus(1'b0, 1'b1, 8'h01, 8'h00);
		bus(1'b1, 1'b0, 8'h01, 8'ha5);
		bus(1'b0, 1'b1, 8'h01, 8'h00);
		cyc(2);
		bus(1'b1, 1'b0, 8'h00, 8'h01);
		cyc(2);
		wait_ready();
		for (int i = 0; i < 4; i++) bus(1'b1, 1'b0, 8'h01, 8'($urandom));
		bus(1'b1, 1'b0, 8'h00, 8'h01);
		bus(1'b1, 1'b0, 8'h00, 8'hff);
		bus(1'b0, 1'b1, 8'h00, 8'h00);
		bus(1'b0, 1'b1, 8'h02, 8'h00);
		bus(1'b1, 1'b0, 8'h03, 8'h55);
		bus(1'b0, 1'b1, 8'h03, 8'h00);
		cyc(2);
		for (int k = 0; k < 8; k++) begin
			// Sleep entry and a code write while asleep; the start must come out on wake, also for k = 3, where standby run is written
			// in the same cycle that standby rises, so the string still halts for one cycle.
			SLEEP_STANDBY <= ~k[2];
			SLEEP_POWERDOWN <= k[2];
			CLK_PER_AVAIL <= k[1];
			bus(1'b1, 1'b0, 8'h00, {k[0], k[1] ^ k[0], 6'h01});
			bus(1'b1, 1'b0, 8'h01, 8'($urandom));
			cyc(3);
			bus(1'b0, 1'b1, 8'h02, 8'h00);
			SLEEP_STANDBY <= 1'b0;
			SLEEP_POWERDOWN <= 1'b0;
			cyc(2);
			wait_ready();
		end
		bus(1'b1, 1'b0, 8'h00, 8'h40);
		bus(1'b1, 1'b0, 8'h01, 8'h3c);
		cyc(3);
		repeat (400) begin
			rnd = $urandom;
			SLEEP_STANDBY <= rnd[8] & rnd[9];
			SLEEP_POWERDOWN <= rnd[10] & rnd[11] & rnd[12];
			CLK_PER_AVAIL <= rnd[13];
			a = {6'h00, rnd[1:0]};
			if (rnd[14] && a == 8'h02) a = 8'h03;
			bus(rnd[2], ~rnd[2] & rnd[3], a, rnd[23:16]);
		end
		cyc(2);
		test_done();
	end
endmodule
`default_nettype wire
